//--- eep_defines.svh
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH
// ==========================================================
// instruction fields
`define EEP_OP_EXT      2'h0
`define EEP_OP_WRITE    2'h1
`define EEP_OP_READ     2'h2
`define EEP_OP_ERASE    2'h3
`define EEP_EXT_LOCK    2'h0
`define EEP_EXT_FILL    2'h1
`define EEP_EXT_CLEAR   2'h2
`define EEP_EXT_UNLOCK  2'h3
// ==========================================================
// organisation (last bit index of each field, and depths)
`define EEP_ALAST_X16   5'h06
`define EEP_ALAST_X8    5'h07
`define EEP_DLAST_X16   5'h0F
`define EEP_DLAST_X8    5'h07
`define EEP_WORDS_X16   128
`define EEP_WORDS_X8    256
`define EEP_ERASED      8'hFF
// ==========================================================
// timing
`define EEP_REF_CLK_MHZ 100
`define EEP_PROG_TIME_MS 10
`define EEP_PROG_CYCLES (`EEP_PROG_TIME_MS * 1000 * `EEP_REF_CLK_MHZ)
`endif

//--- eep_pkg.sv
package eep_pkg;
  // decoded instruction held for the programming side
  typedef enum logic [2:0] {
    CMD_NONE, CMD_READ, CMD_WRITE, CMD_ERASE,
    CMD_UNLOCK, PROGRAM_LOCK_CMD, FILL_ARRAY_CMD, CLEAR_ARRAY_CMD
  } eep_cmd_type;
  // serial receive states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_DONE
  } eep_state_type;
endpackage

//--- eep_port.sv
`include "eep_defines.svh"
// How it works
// R01: word_width_select high gives 128 words of 16 bits with 7 address bits, low 256 bytes with 8.
// R02: an instruction is a start bit of one, a two-bit opcode (10 read, 01 write, 11 erase), then the address.
// R03: opcode 00 with top address bits 11 unlocks programming, with 00 locks it; other bits ignored.
// R04: opcode 00 with top bits 01 takes one data word and programs it into every word.
// R05: opcode 00 with top bits 10 carries no data and erases every word.
// R06: programming starts locked after power-up and stays so until an unlock instruction.
// R07: a programming instruction runs only when unlocked and supply_ok is true, else it is dropped.
// R08: each program cycle is self-timed, erases its target first, and ends within 10 ms.
// R09: once a cycle has started, raising chip_select shows ready/busy on serial_out.
// R10: a read keeps streaming words at rising addresses while clocking goes on with chip_select high.
// R11: the receiver state holds unchanged while serial_clock is stopped with chip_select high.
// R12: a read sends one zero bit before the word, and serial_out changes on rising serial_clock; here it changes on the third ref_clk edge after the rise.
// R13: the fall of chip_select after the last bit starts the programming cycle.
// R14: status shows low while busy and high when ready.
// R15: the read address wraps from the last word to the first until chip_select falls.
// R16: with chip_select low serial_out floats and any partial instruction is dropped.
// R17: clocks with serial_in low before the start bit are ignored.
module eep_port #(
  parameter int PROG_CYCLES = `EEP_PROG_CYCLES
) (
  // system
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // serial link
  input  wire logic serial_clock,
  input  wire logic chip_select,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe,
  // straps and supply monitor
  input  wire logic word_width_select,
  input  wire logic supply_ok
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  // the down counter needs at least two steps to end a cycle
  if (PROG_CYCLES < 2) begin : g_bad_prog_cycles
    $error("PROG_CYCLES must be at least 2");
  end

  logic [7:0] mem [`EEP_WORDS_X8];
  logic [7:0] next_mem [`EEP_WORDS_X8];

  // ==========================================================
  // serial clock domain
  logic                   ser_rst_n;
  eep_pkg::eep_state_type state, next_state;
  logic [4:0]             cnt, next_cnt;
  logic [1:0]             opc, next_opc;
  logic [7:0]             addr, next_addr;
  logic [15:0]            data, next_data;
  logic [15:0]            rdw, next_rdw;
  logic                   bit_out, next_bit_out;
  logic                   rd_active, next_rd_active;
  eep_pkg::eep_cmd_type   cmd_kind, next_cmd_kind;
  logic [7:0]             cmd_addr, next_cmd_addr;
  logic [15:0]            cmd_data, next_cmd_data;
  logic                   cmd_tog, next_cmd_tog;
  logic                   start_tog, next_start_tog;
  logic                   ser_org_m, ser_org;
  logic [4:0]             alast, dlast;
  logic [7:0]             na;
  logic [15:0]            nd;
  logic [1:0]             top;

  // chip_select low clears the receiver at once
  assign ser_rst_n = rst_n & chip_select; // R16

  // array word for the read path; only changes while a cycle runs
  function automatic logic [15:0] word_at(input logic [7:0] a);
    word_at = ser_org ? {mem[{a[6:0], 1'b1}], mem[{a[6:0], 1'b0}]}
                      : {mem[a], 8'h00}; // R01
  endfunction

  // instruction decode and read streaming
  always_comb begin
    alast          = ser_org ? `EEP_ALAST_X16 : `EEP_ALAST_X8;
    dlast          = ser_org ? `EEP_DLAST_X16 : `EEP_DLAST_X8;
    na             = {addr[6:0], serial_in};
    nd             = {data[14:0], serial_in};
    top            = ser_org ? na[6:5] : na[7:6];
    next_state     = state;
    next_cnt       = cnt;
    next_opc       = opc;
    next_addr      = addr;
    next_data      = data;
    next_rdw       = rdw;
    next_bit_out   = bit_out;
    next_rd_active = rd_active;
    next_cmd_kind  = cmd_kind;
    next_cmd_addr  = cmd_addr;
    next_cmd_data  = cmd_data;
    next_cmd_tog   = cmd_tog;
    next_start_tog = start_tog;
    case (state)
      eep_pkg::ST_IDLE: begin
        if (serial_in) begin // R17
          next_state     = eep_pkg::ST_OPC; // R02
          next_cnt       = 5'h00;
          next_start_tog = ~start_tog; // clears status on the far side
        end
      end
      eep_pkg::ST_OPC: begin
        next_opc = {opc[0], serial_in};
        next_cnt = cnt + 5'h01;
        if (cnt == 5'h01) begin
          next_state = eep_pkg::ST_ADDR;
          next_cnt   = 5'h00;
        end
      end
      eep_pkg::ST_ADDR: begin
        next_addr = na;
        next_cnt  = cnt + 5'h01;
        if (cnt == alast) begin // R01
          next_cnt = 5'h00;
          if (opc == `EEP_OP_READ) begin
            next_state     = eep_pkg::ST_READ;
            next_bit_out   = 1'b0; // R12
            next_rd_active = 1'b1;
            next_rdw       = word_at(na);
          end else if (opc == `EEP_OP_WRITE ||
                       (opc == `EEP_OP_EXT && top == `EEP_EXT_FILL)) begin // R04
            next_state = eep_pkg::ST_DATA;
          end else begin
            next_state    = eep_pkg::ST_DONE;
            next_cmd_addr = na;
            next_cmd_tog  = ~cmd_tog;
            if (opc == `EEP_OP_ERASE) begin
              next_cmd_kind = eep_pkg::CMD_ERASE; // R02
            end else if (top == `EEP_EXT_UNLOCK) begin
              next_cmd_kind = eep_pkg::CMD_UNLOCK; // R03
            end else if (top == `EEP_EXT_LOCK) begin
              next_cmd_kind = eep_pkg::PROGRAM_LOCK_CMD; // R03
            end else begin
              next_cmd_kind = eep_pkg::CLEAR_ARRAY_CMD; // R05
            end
          end
        end
      end
      eep_pkg::ST_DATA: begin
        next_data = nd;
        next_cnt  = cnt + 5'h01;
        if (cnt == dlast) begin
          next_state    = eep_pkg::ST_DONE;
          next_cmd_addr = addr;
          next_cmd_data = nd;
          next_cmd_tog  = ~cmd_tog;
          next_cmd_kind = (opc == `EEP_OP_WRITE) ? eep_pkg::CMD_WRITE
                                                 : eep_pkg::FILL_ARRAY_CMD; // R04
        end
      end
      eep_pkg::ST_READ: begin
        next_bit_out = rdw[15]; // R12
        next_cnt     = cnt + 5'h01;
        next_rdw     = {rdw[14:0], 1'b0};
        if (cnt == dlast) begin // R10
          next_cnt  = 5'h00;
          next_addr = ser_org ? {1'b0, addr[6:0] + 7'h01} : addr + 8'h01; // R15
          next_rdw  = word_at(next_addr);
        end
      end
      eep_pkg::ST_DONE: begin
        next_state = eep_pkg::ST_DONE; // extra clocks until chip_select falls
      end
      default: begin
        next_state = eep_pkg::ST_IDLE;
      end
    endcase
  end

  // receiver state: only serial_clock edges and ser_rst_n move it, so a stopped clock holds it
  always_ff @(posedge serial_clock or negedge ser_rst_n) begin // R11
    if (!ser_rst_n) begin
      state     <= eep_pkg::ST_IDLE; // R16
      cnt       <= 5'h00;
      opc       <= 2'h0;
      addr      <= 8'h00;
      data      <= 16'h0000;
      rdw       <= 16'h0000;
      bit_out   <= 1'b0;
      rd_active <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      opc       <= next_opc;
      addr      <= next_addr;
      data      <= next_data;
      rdw       <= next_rdw;
      bit_out   <= next_bit_out;
      rd_active <= next_rd_active;
    end
  end

  // held command survives chip_select low, the far side reads it later
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_kind  <= eep_pkg::CMD_NONE;
      cmd_addr  <= 8'h00;
      cmd_data  <= 16'h0000;
      cmd_tog   <= 1'b0;
      start_tog <= 1'b0;
      ser_org_m <= 1'b0;
      ser_org   <= 1'b0;
    end else begin
      cmd_kind  <= next_cmd_kind;
      cmd_addr  <= next_cmd_addr;
      cmd_data  <= next_cmd_data;
      cmd_tog   <= next_cmd_tog;
      start_tog <= next_start_tog;
      ser_org_m <= word_width_select;
      ser_org   <= ser_org_m;
    end
  end

  // ==========================================================
  // reference clock domain
  logic cs_m, cs_s, cs_d, cs_e, bit_m, bit_s, rd_m, rd_s;
  logic cmd_m, cmd_t2, st_m, st_t2, sup_m, sup_s, org_m, org_s;
  logic                 cmd_seen, next_cmd_seen, st_seen, next_st_seen;
  logic                 wen, next_wen, pend, next_pend;
  logic                 busy, next_busy, show, next_show;
  logic [TW-1:0]        timer, next_timer;
  eep_pkg::eep_cmd_type kind, next_kind;
  logic [7:0]           waddr, next_waddr;
  logic [15:0]          wdata, next_wdata;
  logic                 next_dout, next_oe;
  logic                 cmd_new, cs_fall, start, mem_we, mem_all, mem_erase;

  // programming control
  always_comb begin
    cmd_new       = cmd_t2 != cmd_seen;
    // one stage behind the command toggle, so a quick deselect never loses it
    cs_fall       = cs_e & ~cs_d;
    start         = cs_fall & pend & wen & sup_s & ~busy; // R07 R13
    next_cmd_seen = cmd_t2;
    next_st_seen  = st_t2;
    next_wen      = wen;
    next_pend     = pend;
    next_kind     = kind;
    next_waddr    = waddr;
    next_wdata    = wdata;
    next_busy     = busy;
    next_show     = show;
    next_timer    = timer;
    mem_we        = 1'b0;
    mem_erase     = 1'b0;
    mem_all       = kind == eep_pkg::FILL_ARRAY_CMD || kind == eep_pkg::CLEAR_ARRAY_CMD;
    if (cmd_new) begin
      next_kind  = cmd_kind;
      next_waddr = cmd_addr;
      next_wdata = cmd_data;
      case (cmd_kind)
        eep_pkg::CMD_UNLOCK:       next_wen = 1'b1; // R03
        eep_pkg::PROGRAM_LOCK_CMD: next_wen = 1'b0; // R03
        eep_pkg::CMD_NONE:         next_pend = 1'b0;
        default:                   next_pend = 1'b1;
      endcase
    end
    if (cs_fall) begin
      next_pend = 1'b0; // dropped when locked or supply low
    end
    if (st_t2 != st_seen) begin
      next_show = 1'b0; // a new start bit ends the status display
    end
    if (start) begin
      next_busy  = 1'b1;
      next_show  = 1'b1; // R09
      next_timer = TW'(PROG_CYCLES - 1); // R08
      mem_we     = 1'b1;
      mem_erase  = 1'b1; // R08
    end else if (busy) begin
      next_timer = timer - TW'(1);
      if (timer == '0) begin
        next_busy = 1'b0;
        mem_we    = kind == eep_pkg::CMD_WRITE || kind == eep_pkg::FILL_ARRAY_CMD;
      end
    end
    next_dout = show ? ~busy : bit_s; // R14
    next_oe   = cs_s & (show | rd_s); // R16
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cs_m, cs_s, cs_d, cs_e, bit_m, bit_s, rd_m, rd_s} <= 8'h00;
      {cmd_m, cmd_t2, st_m, st_t2, sup_m, sup_s, org_m, org_s} <= 8'h00;
      cmd_seen      <= 1'b0;
      st_seen       <= 1'b0;
      wen           <= 1'b0; // R06
      pend          <= 1'b0;
      busy          <= 1'b0;
      show          <= 1'b0;
      timer         <= '0;
      kind          <= eep_pkg::CMD_NONE;
      waddr         <= 8'h00;
      wdata         <= 16'h0000;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      {cs_m, cs_s, cs_d, cs_e} <= {chip_select, cs_m, cs_s, cs_d};
      {bit_m, bit_s, rd_m, rd_s} <= {bit_out, bit_m, rd_active, rd_m};
      {cmd_m, cmd_t2, st_m, st_t2} <= {cmd_tog, cmd_m, start_tog, st_m};
      {sup_m, sup_s, org_m, org_s} <= {supply_ok, sup_m, word_width_select, org_m};
      cmd_seen      <= next_cmd_seen;
      st_seen       <= next_st_seen;
      wen           <= next_wen;
      pend          <= next_pend;
      busy          <= next_busy;
      show          <= next_show;
      timer         <= next_timer;
      kind          <= next_kind;
      waddr         <= next_waddr;
      wdata         <= next_wdata;
      serial_out    <= next_dout;
      serial_out_oe <= next_oe;
    end
  end

  // array bytes: erase then write, one byte lane per entry
  for (genvar i = 0; i < `EEP_WORDS_X8; i++) begin : g_mem
    localparam logic [7:0] IDX = 8'(i);
    logic hit;
    always_comb begin
      hit = mem_all | (org_s ? IDX[7:1] == waddr[6:0] : IDX == waddr); // R01
      next_mem[i] = mem[i];
      if (mem_we && hit) begin
        next_mem[i] = mem_erase ? `EEP_ERASED
                    : (org_s && IDX[0]) ? wdata[15:8] : wdata[7:0];
      end
    end
    always_ff @(posedge ref_clk) begin
      mem[i] <= next_mem[i];
    end
  end

  // ==========================================================
  // checks
  a_start_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mem_we && !busy |-> wen && sup_s) else $error("array changed while locked"); // R07
  a_unlock_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_new && cmd_kind == eep_pkg::CMD_UNLOCK |=> wen) else $error("unlock lost"); // R03
  a_lock_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_new && cmd_kind == eep_pkg::PROGRAM_LOCK_CMD |=> !wen) else $error("lock lost"); // R03
  a_wen_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cmd_new |=> wen == $past(wen)) else $error("enable moved without instruction"); // R06
  a_prog_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start |=> busy && timer == TW'(PROG_CYCLES - 1)) else $error("bad cycle length"); // R08
  a_status_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    show && cs_s |=> serial_out_oe && serial_out == !$past(busy)) else $error("bad status"); // R14
  a_float_low_cs: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cs_s |=> !serial_out_oe) else $error("drove with chip_select low"); // R16
  a_pend_dropped: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs_fall |=> !pend) else $error("pending kept after chip_select fall"); // R13
  a_read_dummy: assert property (@(posedge serial_clock) disable iff (!ser_rst_n)
    state == eep_pkg::ST_ADDR && cnt == alast && opc == `EEP_OP_READ
    |=> state == eep_pkg::ST_READ && !bit_out) else $error("no leading zero"); // R12
  a_read_wrap: assert property (@(posedge serial_clock) disable iff (!ser_rst_n)
    state == eep_pkg::ST_READ && cnt == dlast && ser_org && addr[6:0] == 7'h7F
    |=> addr == 8'h00) else $error("read address did not wrap"); // R15
  c_program: cover property (@(posedge ref_clk) disable iff (!rst_n) start ##1 busy);
  c_fill: cover property (@(posedge ref_clk) disable iff (!rst_n)
    start && kind == eep_pkg::FILL_ARRAY_CMD);
  c_read_next: cover property (@(posedge serial_clock) disable iff (!ser_rst_n)
    state == eep_pkg::ST_READ && cnt == dlast);
endmodule // eep_port

//--- eep_host_model.sv
// ==========================================================
// host side of the serial link: makes the link clock only
// inside frames and takes the answer after each rise
module eep_host_model (
  // link lines towards the device
  output logic      serial_clock,
  output logic      chip_select,
  output logic      serial_in,
  // answer from the device
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [47:0] rx_word;
  wire         do_line;

  // undriven line reads as z so a missing enable never matches
  assign do_line = serial_out_oe ? serial_out : 1'bz;

  // idle levels at time zero
  initial begin
    serial_clock = 1'b0;
    chip_select  = 1'b0;
    serial_in    = 1'b0;
    rx_word      = '0;
  end

  // clock stands still around select edges so the crossing sees them
  task automatic select(input logic on);
    #40;
    serial_in   = ~serial_in;  // no stale level while deselected
    chip_select = on;
    #40;
  endtask

  // one 30 ns link clock; the bit of the previous rise is taken 5 ns after this one
  task automatic pulse(input logic b);
    serial_in = b;
    #15 serial_clock = 1'b1;
    #5 rx_word = {rx_word[46:0], do_line};
    #10 serial_clock = 1'b0;
  endtask

  // start bit, opcode, address, data, most significant first
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      pulse(v[i]);
    end
  endtask
endmodule  // eep_host_model

//--- tb_serial_eeprom_command_port.sv
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb_serial_eeprom_command_port;
  timeunit 1ns;
  timeprecision 100ps;

  // short program cycle keeps the run brief
  localparam int PROG = 40;

  logic ref_clk;
  logic rst_n;
  logic word_width_select;
  logic supply_ok;
  wire  serial_clock;
  wire  chip_select;
  wire  serial_in;
  wire  serial_out;
  wire  serial_out_oe;
  int   bad_count;
  int   checks_done;

  // ==========================================================
  // design and host
  eep_port #(.PROG_CYCLES(PROG)) i_eep_port (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .serial_clock      (serial_clock),
    .chip_select       (chip_select),
    .serial_in         (serial_in),
    .serial_out        (serial_out),
    .serial_out_oe     (serial_out_oe),
    .word_width_select (word_width_select),
    .supply_ok         (supply_ok)
  );

  eep_host_model i_eep_host_model (
    .serial_clock  (serial_clock),
    .chip_select   (chip_select),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe)
  );

  // 100 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // tasks
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // odd offset keeps link edges apart from system edges
  task automatic do_reset(input logic wide);
    @(negedge ref_clk);
    rst_n             = 1'b0;
    word_width_select = wide;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    #3.3;
    `CHK(serial_out_oe, 1'b0)
  endtask

  // one complete frame with no answer
  task automatic instr(input logic [31:0] v, input int n);
    i_eep_host_model.select(1'b1);
    i_eep_host_model.send(v, n);
    i_eep_host_model.select(1'b0);
  endtask

  // reselect and judge status; no cycle means the line stays released
  task automatic status(input logic cycle);
    int n = 0;
    i_eep_host_model.select(1'b1);
    if (cycle) begin
      `CHK(serial_out_oe, 1'b1)
      `CHK(serial_out, 1'b0)
      while (serial_out !== 1'b1 && n < PROG + 20) begin
        @(negedge ref_clk);
        n++;
      end
      `CHK(serial_out, 1'b1)
    end else begin
      `CHK(serial_out_oe, 1'b0)
    end
    i_eep_host_model.select(1'b0);
    `CHK(serial_out_oe, 1'b0)
  endtask

  // read dn bits; slow form adds idle zeros and a clock pause
  task automatic read_chk(input logic [31:0] hdr, input int hn, input int dn,
                          input logic [31:0] exp, input logic slow);
    logic [31:0] mask;
    mask = 32'hFFFFFFFF >> (32 - dn);
    i_eep_host_model.select(1'b1);
    if (slow) begin
      i_eep_host_model.send(32'h0, 3);
    end
    i_eep_host_model.send(hdr, hn);
    for (int i = 0; i <= dn; i++) begin
      i_eep_host_model.pulse(1'b0);
      if (slow && i == 4) begin
        #400;
      end
    end
    `CHK(i_eep_host_model.rx_word[dn], 1'b0)
    `CHK(i_eep_host_model.rx_word[31:0] & mask, exp)
    i_eep_host_model.select(1'b0);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_lock_at_start;
    instr({1'h1, 2'h1, 7'h10, 16'h1234}, 26);
    status(1'b0);
    instr({1'h1, 2'h0, 2'h3, 5'h15}, 10);
    instr({1'h1, 2'h0, 2'h2, 5'h0A}, 10);
    status(1'b1);
    read_chk({1'h1, 2'h2, 7'h40}, 10, 32, 32'hFFFFFFFF, 1'b0);
  endtask

  task automatic t_write_wrap;
    instr({1'h1, 2'h1, 7'h7F, 16'hA5C3}, 26);
    status(1'b1);
    instr({1'h1, 2'h1, 7'h00, 16'h1234}, 26);
    status(1'b1);
    read_chk({1'h1, 2'h2, 7'h7F}, 10, 32, 32'hA5C31234, 1'b1);
    instr({1'h1, 2'h3, 7'h7F}, 10);
    status(1'b1);
    read_chk({1'h1, 2'h2, 7'h7F}, 10, 16, 32'h0000FFFF, 1'b0);
  endtask

  task automatic t_refusals;
    i_eep_host_model.select(1'b1);
    i_eep_host_model.send({1'h1, 2'h1, 7'h00, 4'h0}, 14);
    i_eep_host_model.select(1'b0);
    status(1'b0);
    @(negedge ref_clk) supply_ok = 1'b0;
    instr({1'h1, 2'h1, 7'h00, 16'hBEEF}, 26);
    status(1'b0);
    @(negedge ref_clk) supply_ok = 1'b1;
    read_chk({1'h1, 2'h2, 7'h00}, 10, 16, 32'h00001234, 1'b0);
  endtask

  task automatic t_fill_lock;
    instr({1'h1, 2'h0, 2'h1, 5'h1F, 16'h5A3C}, 26);
    status(1'b1);
    read_chk({1'h1, 2'h2, 7'h05}, 10, 32, 32'h5A3C5A3C, 1'b0);
    instr({1'h1, 2'h0, 2'h0, 5'h1F}, 10);
    instr({1'h1, 2'h1, 7'h05, 16'h0000}, 26);
    status(1'b0);
    read_chk({1'h1, 2'h2, 7'h05}, 10, 16, 32'h00005A3C, 1'b0);
  endtask

  // byte mode, then word mode sees the byte pair
  task automatic t_byte_mode;
    do_reset(1'b0);
    instr({1'h1, 2'h0, 2'h3, 6'h2A}, 11);
    instr({1'h1, 2'h1, 8'hFF, 8'h81}, 19);
    status(1'b1);
    instr({1'h1, 2'h1, 8'h00, 8'h7E}, 19);
    status(1'b1);
    read_chk({1'h1, 2'h2, 8'hFF}, 11, 16, 32'h0000817E, 1'b0);
    do_reset(1'b1);
    read_chk({1'h1, 2'h2, 7'h00}, 10, 16, 32'h00005A7E, 1'b0);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    bad_count         = 0;
    checks_done       = 0;
    rst_n             = 1'b0;
    word_width_select = 1'b1;
    supply_ok         = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    #3.3;
    t_lock_at_start();
    t_write_wrap();
    t_refusals();
    t_fill_lock();
    t_byte_mode();
    test_done();
  end

  // all frames together take well under this span
  initial begin
    #200us;
    bad_count++;
    test_done();
  end
endmodule  // tb_serial_eeprom_command_port
